// ===== chan_capture.sv
// One-direction channel capture: counts bits of a 256-bit frame and
// snapshots the selected slot. Assumes strobes on the system clock.
`timescale 1ns/1ps
`default_nettype none
module chan_capture #(
  parameter int unsigned SLOT_BITS = chan_mon_pkg::SLOT_BITS,
  parameter int unsigned SLOTS     = chan_mon_pkg::SLOTS
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Tap
  chan_tap_if.capture tap
);
  // ****************************************
  // Elaboration check
  // ****************************************
  if (SLOT_BITS * SLOTS != (1 << chan_mon_pkg::CNT_W)) begin : g_chk
    $error("chan_capture: frame geometry does not fit the bit counter");
  end

  logic [7:0] cnt_reg,   cnt_next;
  logic [6:0] shift_reg, shift_next;
  logic [7:0] byte_reg,  byte_next;
  logic       stb_reg,   stb_next;
  logic       load;

  // ****************************************
  // Bit counter, shifter and snapshot
  // ****************************************
  // Load only after the slot's last bit, so a read never mixes frames
  always_comb begin
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    byte_next  = byte_reg;
    load       = 1'b0;
    if (tap.bit_stb) begin
      cnt_next   = tap.frame_start ? '0 : cnt_reg + 8'h01;
      shift_next = {shift_reg[5:0], tap.bit_val};
      load       = chan_mon_pkg::slot_last(tap.frame_start ? '0 : cnt_next, tap.sel);
      if (load) begin
        byte_next = {shift_reg, tap.bit_val};
      end
    end
    stb_next = load;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg   <= '0;
      shift_reg <= '0;
      byte_reg  <= chan_mon_pkg::MON_RESET;
      stb_reg   <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      byte_reg  <= byte_next;
      stb_reg   <= stb_next;
    end
  end

  assign tap.mon_byte = byte_reg;
  assign tap.byte_stb = stb_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_byte_order;
    @(posedge i_clk) disable iff (!i_rst_n)
      load |=> (byte_reg == {$past(shift_reg), $past(tap.bit_val)}) && stb_reg;
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("byte order wrong");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !load |=> $stable(byte_reg) && !stb_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed mid frame");

  property p_frame_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      (tap.bit_stb && tap.frame_start) |=> cnt_reg == 8'h00;
  endproperty
  a_frame_zero: assert property (p_frame_zero) else $error("frame start missed");

  property p_load_slot;
    @(posedge i_clk) disable iff (!i_rst_n)
      (tap.bit_stb && !tap.frame_start && cnt_reg[7:3] == tap.sel
       && cnt_reg[2:0] == 3'h6) |=> stb_reg;
  endproperty
  a_load_slot: assert property (p_load_slot) else $error("slot end not loaded");

  c_load: cover property (@(posedge i_clk) disable iff (!i_rst_n) stb_reg);
endmodule : chan_capture
`default_nettype wire

// ===== chan_mon_pkg.sv
// Constants shared by the channel monitor and its capture engine.
// Assumes an 8-bit register port with 6-bit byte addresses.
`default_nettype none
package chan_mon_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned DATA_W        = 8;
  localparam logic [5:0]  OFF_TX_CTRL   = 6'h14;
  localparam logic [5:0]  OFF_RX_CTRL   = 6'h15;
  localparam logic [5:0]  OFF_TX_MON    = 6'h22;
  localparam logic [5:0]  OFF_RX_MON    = 6'h2a;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  MON_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  // ****************************************
  // Field positions in both control registers
  // ****************************************
  localparam int unsigned BIT_HI  = 7;  // remote loopback / line-interface reset
  localparam int unsigned BIT_MID = 6;  // local loopback / elastic align
  localparam int unsigned BIT_LO  = 5;  // alarm generation / elastic reset
  localparam int unsigned SEL_MSB = 4;
  localparam int unsigned SEL_W   = 5;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int unsigned SLOT_BITS = 8;
  localparam int unsigned SLOTS     = 32;
  localparam int unsigned CNT_W     = 8;
  localparam logic [2:0]  LAST_BIT  = 3'h7;

  // Pin synchroniser bundle: clock, data, frame sync per direction
  localparam int unsigned PIN_W   = 6;
  localparam int unsigned TX_CLK  = 0;
  localparam int unsigned TX_DAT  = 1;
  localparam int unsigned TX_FS   = 2;
  localparam int unsigned RX_CLK  = 3;
  localparam int unsigned RX_DAT  = 4;
  localparam int unsigned RX_FS   = 5;

  // True on the last bit of the selected slot
  function automatic logic slot_last(input logic [7:0] cnt, input logic [4:0] sel);
    slot_last = (cnt[7:3] == sel) && (cnt[2:0] == LAST_BIT);
  endfunction : slot_last
endpackage : chan_mon_pkg
`default_nettype wire

// ===== chan_mon_top.sv
// Channel monitor top: control registers, pin sync, two capture engines.
// Assumes line clock, data and frame-sync pins, with data changing on the
// falling line clock edge, and line clocks well below the 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module chan_mon_top (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Register port
  input  wire logic [5:0] i_addr,
  input  wire logic       i_wr_stb,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Line pins
  input  wire logic       i_tx_line_clk,
  input  wire logic       i_tx_line_data,
  input  wire logic       i_tx_frame_sync,
  input  wire logic       i_rx_line_clk,
  input  wire logic       i_rx_line_data,
  input  wire logic       i_rx_frame_sync,
  // Control fields to neighbouring blocks
  output logic            o_remote_loopback_en,
  output logic            o_local_loopback_en,
  output logic            o_line_alarm_gen_en,
  output logic            o_line_interface_reset,
  output logic            o_rx_elastic_align,
  output logic            o_rx_elastic_reset,
  output logic      [4:0] o_tx_slot_sel,
  output logic      [4:0] o_rx_slot_sel
);
  localparam int unsigned PW = chan_mon_pkg::PIN_W;

  logic [7:0]    common_control_three_reg, common_control_three_next;
  logic [7:0]    common_control_four_reg,  common_control_four_next;
  logic [7:0]    rdata_reg,                rdata_next;
  logic [PW-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
  logic [PW-1:0] agree;
  logic          tx_rise, rx_rise;

  chan_tap_if tx_if ();
  chan_tap_if rx_if ();

  // ****************************************
  // Register port
  // ****************************************
  // Whole-byte writes; software read-modify-writes to keep the upper bits
  always_comb begin
    common_control_three_next = common_control_three_reg;
    common_control_four_next  = common_control_four_reg;
    if (i_wr_stb && i_addr == chan_mon_pkg::OFF_TX_CTRL) begin
      common_control_three_next = i_wdata;
    end
    if (i_wr_stb && i_addr == chan_mon_pkg::OFF_RX_CTRL) begin
      common_control_four_next = i_wdata;
    end
    case (i_addr)
      chan_mon_pkg::OFF_TX_CTRL: rdata_next = common_control_three_reg;
      chan_mon_pkg::OFF_RX_CTRL: rdata_next = common_control_four_reg;
      chan_mon_pkg::OFF_TX_MON:  rdata_next = tx_if.mon_byte;
      chan_mon_pkg::OFF_RX_MON:  rdata_next = rx_if.mon_byte;
      default:                   rdata_next = chan_mon_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      common_control_three_reg <= chan_mon_pkg::CTRL_RESET;
      common_control_four_reg  <= chan_mon_pkg::CTRL_RESET;
      rdata_reg                <= chan_mon_pkg::UNMAPPED_READ;
    end else begin
      common_control_three_reg <= common_control_three_next;
      common_control_four_reg  <= common_control_four_next;
      rdata_reg                <= rdata_next;
    end
  end

  // Outputs taken straight from the read-data and control flops
  assign o_rdata                = rdata_reg;
  assign o_remote_loopback_en   = common_control_three_reg[chan_mon_pkg::BIT_HI];
  assign o_local_loopback_en    = common_control_three_reg[chan_mon_pkg::BIT_MID];
  assign o_line_alarm_gen_en    = common_control_three_reg[chan_mon_pkg::BIT_LO];
  assign o_line_interface_reset = common_control_four_reg[chan_mon_pkg::BIT_HI];
  assign o_rx_elastic_align     = common_control_four_reg[chan_mon_pkg::BIT_MID];
  assign o_rx_elastic_reset     = common_control_four_reg[chan_mon_pkg::BIT_LO];
  assign o_tx_slot_sel          = common_control_three_reg[chan_mon_pkg::SEL_MSB:0];
  assign o_rx_slot_sel          = common_control_four_reg[chan_mon_pkg::SEL_MSB:0];

  // ****************************************
  // Pin synchronisers and filter
  // ****************************************
  // A level counts only once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);

  always_comb begin
    filt_next = (agree & sync3_reg) | (~agree & filt_reg);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
    end else begin
      sync1_reg <= {i_rx_frame_sync, i_rx_line_data, i_rx_line_clk,
                    i_tx_frame_sync, i_tx_line_data, i_tx_line_clk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  // Rising line clock edges; data and sync travel the same path, so they line up
  assign tx_rise = filt_next[chan_mon_pkg::TX_CLK] & ~filt_reg[chan_mon_pkg::TX_CLK];
  assign rx_rise = filt_next[chan_mon_pkg::RX_CLK] & ~filt_reg[chan_mon_pkg::RX_CLK];

  // ****************************************
  // Capture engines, one per direction
  // ****************************************
  assign tx_if.bit_stb     = tx_rise;
  assign tx_if.bit_val     = filt_next[chan_mon_pkg::TX_DAT];
  assign tx_if.frame_start = filt_next[chan_mon_pkg::TX_FS];
  assign tx_if.sel         = common_control_three_reg[chan_mon_pkg::SEL_MSB:0];
  assign rx_if.bit_stb     = rx_rise;
  assign rx_if.bit_val     = filt_next[chan_mon_pkg::RX_DAT];
  assign rx_if.frame_start = filt_next[chan_mon_pkg::RX_FS];
  assign rx_if.sel         = common_control_four_reg[chan_mon_pkg::SEL_MSB:0];

  // Two independent engines let both directions run at once
  chan_capture u_tx_capture (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .tap     (tx_if.capture)
  );

  chan_capture u_rx_capture (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .tap     (rx_if.capture)
  );

  // ****************************************
  // Assertions
  // ****************************************
  property p_tx_sel;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_stb && i_addr == chan_mon_pkg::OFF_TX_CTRL) |=>
        tx_if.sel == $past(i_wdata[chan_mon_pkg::SEL_MSB:0]);
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("transmit select not stored");

  property p_rx_sel;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_stb && i_addr == chan_mon_pkg::OFF_RX_CTRL) |=>
        rx_if.sel == $past(i_wdata[chan_mon_pkg::SEL_MSB:0]);
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("receive select not stored");

  // Writes elsewhere, read-only bytes included, must not disturb the control bytes
  property p_tx_ctrl_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !(i_wr_stb && i_addr == chan_mon_pkg::OFF_TX_CTRL) |=> $stable(common_control_three_reg);
  endproperty
  a_tx_ctrl_hold: assert property (p_tx_ctrl_hold) else $error("transmit control changed");

  property p_rx_ctrl_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !(i_wr_stb && i_addr == chan_mon_pkg::OFF_RX_CTRL) |=> $stable(common_control_four_reg);
  endproperty
  a_rx_ctrl_hold: assert property (p_rx_ctrl_hold) else $error("receive control changed");

  property p_tx_mon_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_addr == chan_mon_pkg::OFF_TX_MON |=> o_rdata == $past(tx_if.mon_byte);
  endproperty
  a_tx_mon_read: assert property (p_tx_mon_read) else $error("transmit byte read wrong");

  property p_rx_mon_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_addr == chan_mon_pkg::OFF_RX_MON |=> o_rdata == $past(rx_if.mon_byte);
  endproperty
  a_rx_mon_read: assert property (p_rx_mon_read) else $error("receive byte read wrong");

  property p_tx_upper;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_stb && i_addr == chan_mon_pkg::OFF_TX_CTRL) |=>
        {o_remote_loopback_en, o_local_loopback_en, o_line_alarm_gen_en}
          == $past(i_wdata[chan_mon_pkg::BIT_HI:chan_mon_pkg::BIT_LO]);
  endproperty
  a_tx_upper: assert property (p_tx_upper) else $error("transmit control bits wrong");

  property p_rx_upper;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_wr_stb && i_addr == chan_mon_pkg::OFF_RX_CTRL) |=>
        {o_line_interface_reset, o_rx_elastic_align, o_rx_elastic_reset}
          == $past(i_wdata[chan_mon_pkg::BIT_HI:chan_mon_pkg::BIT_LO]);
  endproperty
  a_rx_upper: assert property (p_rx_upper) else $error("receive control bits wrong");

  property p_slot_out;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_tx_slot_sel == tx_if.sel) && (o_rx_slot_sel == rx_if.sel);
  endproperty
  a_slot_out: assert property (p_slot_out) else $error("slot select outputs differ");

  property p_unmapped;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_addr == 6'h00) |=> o_rdata == chan_mon_pkg::UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_tx_write: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr_stb && i_addr == chan_mon_pkg::OFF_TX_CTRL);
  c_tx_read:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
    tx_if.byte_stb ##1 i_addr == chan_mon_pkg::OFF_TX_MON);
  c_rx_read:  cover property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_if.byte_stb ##1 i_addr == chan_mon_pkg::OFF_RX_MON);
endmodule : chan_mon_top
`default_nettype wire

// ===== chan_mon_top_bench.sv
// Self-checking bench for the channel monitor top.
// Assumes the bench drives every pin itself; line clocks run 8 system clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module chan_mon_top_bench;
  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic       i_clk;
  logic       i_rst_n;
  logic [5:0] i_addr;
  logic       i_wr_stb;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic       i_tx_line_clk;
  logic       i_tx_line_data;
  logic       i_tx_frame_sync;
  logic       i_rx_line_clk;
  logic       i_rx_line_data;
  logic       i_rx_frame_sync;
  logic       o_remote_loopback_en;
  logic       o_local_loopback_en;
  logic       o_line_alarm_gen_en;
  logic       o_line_interface_reset;
  logic       o_rx_elastic_align;
  logic       o_rx_elastic_reset;
  logic [4:0] o_tx_slot_sel;
  logic [4:0] o_rx_slot_sel;
  int         errors;
  int         checked;
  logic [7:0] tx_frame [32];
  logic [7:0] rx_frame [32];
  logic [7:0] prev_tx;
  logic [7:0] prev_rx;
  logic [7:0] tx_ctrl_seen;
  logic [7:0] rx_ctrl_seen;
  logic       park_rx;

  chan_mon_top u_chan_mon_top (
    .i_clk                  (i_clk),
    .i_rst_n                (i_rst_n),
    .i_addr                 (i_addr),
    .i_wr_stb               (i_wr_stb),
    .i_wdata                (i_wdata),
    .o_rdata                (o_rdata),
    .i_tx_line_clk          (i_tx_line_clk),
    .i_tx_line_data         (i_tx_line_data),
    .i_tx_frame_sync        (i_tx_frame_sync),
    .i_rx_line_clk          (i_rx_line_clk),
    .i_rx_line_data         (i_rx_line_data),
    .i_rx_frame_sync        (i_rx_frame_sync),
    .o_remote_loopback_en   (o_remote_loopback_en),
    .o_local_loopback_en    (o_local_loopback_en),
    .o_line_alarm_gen_en    (o_line_alarm_gen_en),
    .o_line_interface_reset (o_line_interface_reset),
    .o_rx_elastic_align     (o_rx_elastic_align),
    .o_rx_elastic_reset     (o_rx_elastic_reset),
    .o_tx_slot_sel          (o_tx_slot_sel),
    .o_rx_slot_sel          (o_rx_slot_sel)
  );

  // Control outputs gathered back into register layout
  assign tx_ctrl_seen = {o_remote_loopback_en, o_local_loopback_en,
                         o_line_alarm_gen_en, o_tx_slot_sel};
  assign rx_ctrl_seen = {o_line_interface_reset, o_rx_elastic_align,
                         o_rx_elastic_reset, o_rx_slot_sel};

  // 40 MHz system clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Line order: the octet goes out MSB first
  function automatic logic line_bit(input logic [7:0] octet, input int pos);
    line_bit = octet[7 - pos];
  endfunction : line_bit

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // One-cycle write strobe, launched off the falling edge
  task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    i_addr   = addr;
    i_wdata  = data;
    i_wr_stb = 1'b1;
    @(negedge i_clk);
    i_wr_stb = 1'b0;
  endtask : write_reg

  // Read data is registered, so it is looked at one cycle after the address
  task automatic read_reg(input logic [5:0] addr, input logic [7:0] exp);
    @(negedge i_clk);
    i_addr = addr;
    @(negedge i_clk);
    check(o_rdata, exp);
  endtask : read_reg

  // Program both selects, then send one random frame in each direction at once
  task automatic run_frame(input logic [4:0] tsel, input logic [4:0] rsel);
    logic [7:0] tv;
    logic [7:0] rv;
    tv = {3'($urandom), tsel};
    rv = {3'($urandom), rsel};
    for (int s = 0; s < 32; s++) begin
      tx_frame[s] = 8'($urandom);
      rx_frame[s] = 8'($urandom);
    end
    write_reg(chan_mon_pkg::OFF_TX_CTRL, tv);
    write_reg(chan_mon_pkg::OFF_RX_CTRL, rv);
    check(tx_ctrl_seen, tv);
    check(rx_ctrl_seen, rv);
    read_reg(chan_mon_pkg::OFF_TX_CTRL, tv);
    read_reg(chan_mon_pkg::OFF_RX_CTRL, rv);
    // Park on one monitor byte, alternating per frame, so each is watched mid-frame
    park_rx = ~park_rx;
    i_addr  = park_rx ? chan_mon_pkg::OFF_RX_MON : chan_mon_pkg::OFF_TX_MON;
    for (int b = 0; b < 256; b++) begin
      @(negedge i_clk);
      i_tx_line_clk   = 1'b0;
      i_rx_line_clk   = 1'b0;
      i_tx_line_data  = line_bit(tx_frame[b / 8], b % 8);
      i_rx_line_data  = line_bit(rx_frame[b / 8], b % 8);
      i_tx_frame_sync = (b == 0);
      i_rx_frame_sync = (b == 0);
      if (!park_rx && b == 8 * int'(tsel)) begin
        check(o_rdata, prev_tx);
      end
      if (park_rx && b == 8 * int'(rsel)) begin
        check(o_rdata, prev_rx);
      end
      repeat (3) @(negedge i_clk);
      i_tx_line_clk = 1'b1;
      i_rx_line_clk = 1'b1;
      repeat (4) @(negedge i_clk);
    end
    // Let the last bit clear the synchroniser before reading
    repeat (8) @(negedge i_clk);
    read_reg(chan_mon_pkg::OFF_TX_MON, tx_frame[tsel]);
    read_reg(chan_mon_pkg::OFF_RX_MON, rx_frame[rsel]);
    prev_tx = tx_frame[tsel];
    prev_rx = rx_frame[rsel];
  endtask : run_frame

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_rst_n         = 1'b0;
    i_addr          = 6'h00;
    i_wr_stb        = 1'b0;
    i_wdata         = 8'h00;
    i_tx_line_clk   = 1'b0;
    i_tx_line_data  = 1'b0;
    i_tx_frame_sync = 1'b0;
    i_rx_line_clk   = 1'b0;
    i_rx_line_data  = 1'b0;
    i_rx_frame_sync = 1'b0;
    errors          = 0;
    checked         = 0;
    prev_tx         = chan_mon_pkg::MON_RESET;
    prev_rx         = chan_mon_pkg::MON_RESET;
    park_rx         = 1'b1;
    void'($urandom(70723));
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    read_reg(chan_mon_pkg::OFF_TX_CTRL, chan_mon_pkg::CTRL_RESET);
    read_reg(chan_mon_pkg::OFF_RX_CTRL, chan_mon_pkg::CTRL_RESET);
    read_reg(chan_mon_pkg::OFF_TX_MON, chan_mon_pkg::MON_RESET);
    read_reg(chan_mon_pkg::OFF_RX_MON, chan_mon_pkg::MON_RESET);
    // Unmapped place: write ignored, reads back the idle value
    write_reg(6'h3f, 8'h5a);
    read_reg(6'h3f, chan_mon_pkg::UNMAPPED_READ);
    // A middle pair first, then the edge slots, then random ones
    run_frame(5'h06, 5'h0f);
    run_frame(5'h00, 5'h1f);
    run_frame(5'h1f, 5'h00);
    for (int i = 0; i < 5; i++) begin
      run_frame(5'($urandom), 5'($urandom));
    end
    // Monitor bytes are read-only
    write_reg(chan_mon_pkg::OFF_TX_MON, ~prev_tx);
    write_reg(chan_mon_pkg::OFF_RX_MON, ~prev_rx);
    read_reg(chan_mon_pkg::OFF_TX_MON, prev_tx);
    read_reg(chan_mon_pkg::OFF_RX_MON, prev_rx);
    summarize();
  end

  // Eight frames take about 17,000 cycles; 40,000, over twice that, means a hang
  initial begin
    repeat (40000) @(posedge i_clk);
    errors++;
    summarize();
  end
endmodule : chan_mon_top_bench
`default_nettype wire

// ===== chan_tap_if.sv
// Carrier between the monitor top and one capture engine.
// Assumes bit strobes are one clock wide and already synchronised.
`timescale 1ns/1ps
`default_nettype none
interface chan_tap_if;
  logic       bit_stb;      // One cycle per line bit
  logic       bit_val;      // Line bit, valid with bit_stb
  logic       frame_start;  // Marks first bit of the frame
  logic [4:0] sel;          // Selected channel
  logic [7:0] mon_byte;     // Last completed byte
  logic       byte_stb;     // Pulse when mon_byte renews

  modport source  (output bit_stb, bit_val, frame_start, sel,
                   input  mon_byte, byte_stb);
  modport capture (input  bit_stb, bit_val, frame_start, sel,
                   output mon_byte, byte_stb);
endinterface : chan_tap_if
`default_nettype wire
